/* File: verilog/fpt_host.sv */
// Purpose: Host end; AHB-Lite registers in, serial programming words out.
// Assumes: Single AHB-Lite master, word transfers only, one slave.
// Notes:   Only single word transfers; hsize is not decoded.
`timescale 1ns/100ps
`default_nettype none

module fpt_host (
	input  wire logic        hclk,       // system clock
	input  wire logic        hresetn,    // async reset, active low
	input  wire logic        hsel,       // slave select
	input  wire logic [31:0] haddr,      // byte address
	input  wire logic [1:0]  htrans,     // transfer type
	input  wire logic        hwrite,     // write when high
	input  wire logic [2:0]  hsize,      // word size only
	input  wire logic [31:0] hwdata,     // write data
	input  wire logic        hready,     // bus ready
	output logic      [31:0] hrdata,     // read data
	output logic             hreadyout,  // this slave ready
	output logic             hresp,      // always OKAY
	fpt_ser_if.host          ser         // serial programming link
);

	// ****************************************************************
	// State
	// ****************************************************************
	fpt_pkg::fpt_ser_e st_q;
	logic [3:0]        tmr_q;
	logic [4:0]        bit_q;
	logic [23:0]       sh_q;
	logic [23:0]       nxt_q;
	logic [23:0]       nxt2_q;
	logic [1:0]        npend_q;
	logic              dp_wr_q;
	logic [7:0]        dp_ofs_q;
	logic [1:0]        ctrl_q;
	logic [21:0]       den_q;
	logic [9:0]        tune_q;
	logic              refused_q;
	logic              dforced_q;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire       ap     = hsel && htrans[1] && hready;
	wire [7:0] a_ofs  = haddr[7:0];
	wire       a_send = (a_ofs == fpt_pkg::OFS_DEN) || (a_ofs == fpt_pkg::OFS_TUNE);
	wire       busy   = (npend_q != 2'h0) || (st_q != fpt_pkg::FPT_IDLE);

	// Writes that start a serial word are held in wait states until the
	// link is free; this is the only back-pressure the software sees.
	wire dp_go   = dp_wr_q && (hreadyout || !busy);
	wire wr_ctrl = dp_go && (dp_ofs_q == fpt_pkg::OFS_CTRL);
	wire wr_den  = dp_go && (dp_ofs_q == fpt_pkg::OFS_DEN);
	wire wr_tune = dp_go && (dp_ofs_q == fpt_pkg::OFS_TUNE);
	wire wr_stat = dp_go && (dp_ofs_q == fpt_pkg::OFS_STAT);

	// ****************************************************************
	// Denominator words
	// ****************************************************************
	wire        wsel    = ctrl_q[fpt_pkg::CTRL_WSEL];
	wire        num_z   = ctrl_q[fpt_pkg::CTRL_NUMZ];
	wire [21:0] den_in  = hwdata[21:0];
	// A narrow denominator above the 12-bit range cannot be represented.
	wire        den_bad = !wsel && (den_in >= fpt_pkg::DEN_SMALL);
	// The upper field is the value's own top bits, hence zero below 4096.
	wire [9:0]  den_up  = wsel ? den_in[21:12] : 10'h000;
	wire [23:0] w_up    = {den_up, 10'h000, fpt_pkg::CTL_DEN_UP};
	wire [23:0] w_lo    = {7'h00, wsel, den_in[11:0], fpt_pkg::CTL_DEN_LO};

	// ****************************************************************
	// Tuning word
	// ****************************************************************
	wire [2:0] t_pump   = hwdata[fpt_pkg::TUNE_PUMP_LSB +: 3];
	wire [1:0] t_boost  = hwdata[fpt_pkg::TUNE_BST_LSB +: 2];
	wire [1:0] t_dither = hwdata[fpt_pkg::TUNE_DTH_LSB +: 2];

	wire pump_ok   = (t_pump == fpt_pkg::PUMP_MIN) || (t_pump == fpt_pkg::PUMP_MAX)
		|| (t_pump == fpt_pkg::PUMP_NOM);
	wire boost_ok  = (t_boost == fpt_pkg::BOOST_DOUBLE)
		|| (t_boost == fpt_pkg::BOOST_OFF);
	wire dither_ok = (t_dither == fpt_pkg::DITHER_ON)
		|| (t_dither == fpt_pkg::DITHER_OFF);
	wire tune_ok   = pump_ok && boost_ok && dither_ok;

	wire [21:0] den_eff     = wsel ? den_q : {10'h000, den_q[11:0]};
	// Dithering is forced off rather than refused, so the pump and boost
	// settings of the same write still take effect.
	wire        dither_veto = (t_dither == fpt_pkg::DITHER_ON)
		&& ((den_eff < fpt_pkg::DITHER_MIN_DEN) || num_z);
	wire [1:0]  s_dither    = dither_veto ? fpt_pkg::DITHER_OFF : t_dither;
	wire [23:0] w_tune      = {4'h0, s_dither, 6'h00, t_boost, 2'h0, t_pump, 1'b0,
		fpt_pkg::CTL_TUNE};

	wire refuse = (wr_den && den_bad) || (wr_tune && !tune_ok);
	wire forced = wr_tune && tune_ok && dither_veto;

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	wire [31:0] rd_val =
		(a_ofs == fpt_pkg::OFS_CTRL) ? {30'h0000_0000, ctrl_q} :
		(a_ofs == fpt_pkg::OFS_DEN)  ? {10'h000, den_q} :
		(a_ofs == fpt_pkg::OFS_TUNE) ? {22'h00_0000, tune_q} :
		(a_ofs == fpt_pkg::OFS_STAT) ? {29'h0000_0000, dforced_q, refused_q, busy} :
		32'h0000_0000;

	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q   <= 1'b0;
			dp_ofs_q  <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
		end else begin
			if (ap) begin
				dp_wr_q  <= hwrite;
				dp_ofs_q <= a_ofs;
				hrdata   <= rd_val;
			end else if (dp_go) begin
				dp_wr_q <= 1'b0;
			end
			if (ap && hwrite && a_send) begin
				hreadyout <= 1'b0;
			end else if (!hreadyout && !busy) begin
				hreadyout <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q    <= 2'h0;
			den_q     <= 22'h00_0000;
			tune_q    <= {fpt_pkg::RST_DITHER, 2'h0, fpt_pkg::RST_BOOST, 1'b0,
				fpt_pkg::RST_PUMP};
			refused_q <= 1'b0;
			dforced_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= hwdata[1:0];
			end
			if (wr_den && !den_bad) begin
				den_q <= den_in;
			end
			if (wr_tune && tune_ok) begin
				tune_q <= {s_dither, 2'h0, t_boost, 1'b0, t_pump};
			end
			// A new event wins over a clear in the same cycle.
			refused_q <= refuse
				|| (refused_q && !(wr_stat && hwdata[fpt_pkg::STAT_REFUSED]));
			dforced_q <= forced
				|| (dforced_q && !(wr_stat && hwdata[fpt_pkg::STAT_DFORCED]));
		end
	end

	// ****************************************************************
	// Word queue
	// ****************************************************************
	wire take = (st_q == fpt_pkg::FPT_IDLE) && (npend_q != 2'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nxt_q   <= 24'h00_0000;
			nxt2_q  <= 24'h00_0000;
			npend_q <= 2'h0;
		end else if (wr_den && !den_bad) begin
			// Upper field first, so the width select arrives last.
			nxt_q   <= w_up;
			nxt2_q  <= w_lo;
			npend_q <= 2'h2;
		end else if (wr_tune && tune_ok) begin
			nxt_q   <= w_tune;
			npend_q <= 2'h1;
		end else if (take) begin
			nxt_q   <= nxt2_q;
			npend_q <= npend_q - 2'h1;
		end
	end

	// ****************************************************************
	// Serial shifter
	// ****************************************************************
	wire tdone = (tmr_q == 4'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmr_q <= 4'h0;
		end else if (tdone || (st_q == fpt_pkg::FPT_IDLE)) begin
			tmr_q <= fpt_pkg::SER_HALF_M1;
		end else begin
			tmr_q <= tmr_q - 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q         <= fpt_pkg::FPT_IDLE;
			bit_q        <= 5'h00;
			sh_q         <= 24'h00_0000;
			ser.ser_clk  <= 1'b0;
			ser.ser_data <= 1'b0;
			ser.ser_le   <= 1'b0;
		end else begin
			unique case (st_q)
				fpt_pkg::FPT_IDLE: begin
					if (take) begin
						sh_q         <= nxt_q;
						ser.ser_data <= nxt_q[23];
						bit_q        <= fpt_pkg::WORD_MSB;
						st_q         <= fpt_pkg::FPT_LOW;
					end
				end
				fpt_pkg::FPT_LOW: begin
					if (tdone) begin
						ser.ser_clk <= 1'b1;
						st_q        <= fpt_pkg::FPT_HIGH;
					end
				end
				fpt_pkg::FPT_HIGH: begin
					if (tdone) begin
						ser.ser_clk <= 1'b0;
						if (bit_q == 5'h00) begin
							ser.ser_le <= 1'b1;
							st_q       <= fpt_pkg::FPT_LATCH;
						end else begin
							bit_q        <= bit_q - 5'h01;
							sh_q         <= {sh_q[22:0], 1'b0};
							ser.ser_data <= sh_q[22];
							st_q         <= fpt_pkg::FPT_LOW;
						end
					end
				end
				fpt_pkg::FPT_LATCH: begin
					if (tdone) begin
						ser.ser_le <= 1'b0;
						st_q       <= fpt_pkg::FPT_IDLE;
					end
				end
			endcase
		end
	end

endmodule : fpt_host

`default_nettype wire

/* File: verilog/fpt_pkg.sv */
// Purpose: Shared constants for the fractional synthesizer tuning port.
// Assumes: One 25 MHz clock on both ends of the serial programming link.
// Notes:   Serial words are 24 bits, sent MSB first, low four bits address.

package fpt_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int         CLK_NS       = 40;
	localparam int         SER_HALF_NS  = 50;
	localparam int         SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SER_HALF_M1  = 4'(SER_HALF_CYC - 1);

	// ****************************************************************
	// Serial word layout
	// ****************************************************************
	localparam logic [4:0] WORD_LEN    = 5'h18;
	localparam logic [4:0] WORD_MSB    = 5'h17;
	localparam logic [3:0] CTL_DEN_UP  = 4'hd;
	localparam logic [3:0] CTL_DEN_LO  = 4'h6;
	localparam logic [3:0] CTL_TUNE    = 4'hf;
	localparam int         DEN_UP_LSB  = 14;
	localparam int         DEN_LO_LSB  = 4;
	localparam int         WSEL_BIT    = 16;
	localparam int         DITHER_LSB  = 18;
	localparam int         BOOST_LSB   = 10;
	localparam int         PUMP_LSB    = 5;

	// ****************************************************************
	// Field codes and limits
	// ****************************************************************
	localparam logic [2:0]  PUMP_MIN       = 3'h2;
	localparam logic [2:0]  PUMP_MAX       = 3'h3;
	localparam logic [2:0]  PUMP_NOM       = 3'h7;
	localparam logic [1:0]  BOOST_DOUBLE   = 2'h2;
	localparam logic [1:0]  BOOST_OFF      = 2'h3;
	localparam logic [1:0]  DITHER_ON      = 2'h0;
	localparam logic [1:0]  DITHER_OFF     = 2'h3;
	localparam logic [21:0] DEN_SMALL      = 22'h00_1000;
	localparam logic [21:0] DITHER_MIN_DEN = 22'h00_03e8;

	// ****************************************************************
	// Reset values of the device fields
	// ****************************************************************
	localparam logic        RST_WSEL   = 1'b0;
	localparam logic [11:0] RST_FD_LO  = 12'h000;
	localparam logic [9:0]  RST_FD_UP  = 10'h000;
	localparam logic [2:0]  RST_PUMP   = PUMP_NOM;
	localparam logic [1:0]  RST_BOOST  = BOOST_OFF;
	localparam logic [1:0]  RST_DITHER = DITHER_OFF;

	// ****************************************************************
	// Host register map (byte offsets) and fields
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_DEN       = 8'h04;
	localparam logic [7:0] OFS_TUNE      = 8'h08;
	localparam logic [7:0] OFS_STAT      = 8'h0c;
	localparam int         CTRL_WSEL     = 0;
	localparam int         CTRL_NUMZ     = 1;
	localparam int         TUNE_PUMP_LSB = 0;
	localparam int         TUNE_BST_LSB  = 4;
	localparam int         TUNE_DTH_LSB  = 8;
	localparam int         STAT_BUSY     = 0;
	localparam int         STAT_REFUSED  = 1;
	localparam int         STAT_DFORCED  = 2;

	typedef enum logic [1:0] {
		FPT_IDLE  = 2'b00,
		FPT_LOW   = 2'b01,
		FPT_HIGH  = 2'b11,
		FPT_LATCH = 2'b10
	} fpt_ser_e;

endpackage : fpt_pkg

/* File: verilog/fpt_ser_if.sv */
// Purpose: Three-line serial programming link between host and device.
// Assumes: Both ends run on hclk; the device synchronises what it samples.
// Notes:   All three lines are driven by the host only.
`timescale 1ns/100ps
`default_nettype none

interface fpt_ser_if (
	input wire logic hclk,    // common clock
	input wire logic hresetn  // async reset, active low
);
	logic ser_clk;
	logic ser_data;
	logic ser_le;

	modport host (output ser_clk, output ser_data, output ser_le);
	modport dev  (input ser_clk, input ser_data, input ser_le);
endinterface : fpt_ser_if

`default_nettype wire

/* File: verilog/fpt_dev.sv */
// Purpose: Device end; takes serial words and holds the tuning fields.
// Assumes: Host keeps its own obligations on reserved codes and zero bits.
// Notes:   Decoded outputs lag a latched word by one clock.
`timescale 1ns/100ps
`default_nettype none

module fpt_dev (
	input  wire logic        hclk,          // system clock
	input  wire logic        hresetn,       // async reset, active low
	fpt_ser_if.dev           ser,           // serial programming link
	output logic      [21:0] den,           // effective fractional denominator
	output logic             den_wide,      // 22-bit denominator mode
	output logic      [2:0]  pump_mode,     // pump mode code, current unchanged
	output logic             boost_double,  // double pump current in fastlock
	output logic             dither_en,     // modulator dithering enabled
	output logic             code_err       // a held field has a reserved code
);

	// ****************************************************************
	// Pin synchronisers and edge detection
	// ****************************************************************
	logic [2:0]  s1_q;
	logic [2:0]  s2_q;
	logic [2:0]  s3_q;
	logic [23:0] sh_q;
	logic [4:0]  cnt_q;
	logic        wsel_q;
	logic [11:0] fd_lo_q;
	logic [9:0]  fd_up_q;
	logic [2:0]  pump_q;
	logic [1:0]  boost_q;
	logic [1:0]  dither_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
		end else begin
			s1_q <= {ser.ser_le, ser.ser_clk, ser.ser_data};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	wire       din      = s2_q[0];
	wire       clk_rise = s2_q[1] && !s3_q[1];
	wire       le_high  = s2_q[2];
	wire       le_rise  = s2_q[2] && !s3_q[2];
	wire       latch    = le_rise && (cnt_q == fpt_pkg::WORD_LEN);
	wire [3:0] ctl      = sh_q[3:0];

	// ****************************************************************
	// Shift register and bit count
	// ****************************************************************
	// A word of any other length is dropped, so a glitch on the clock line
	// cannot shift a stale bit into a field.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_q  <= 24'h00_0000;
			cnt_q <= 5'h00;
		end else if (le_high) begin
			cnt_q <= 5'h00;
		end else if (clk_rise) begin
			sh_q <= {sh_q[22:0], din};
			if (cnt_q <= fpt_pkg::WORD_LEN) begin
				cnt_q <= cnt_q + 5'h01;
			end
		end
	end

	// ****************************************************************
	// Field registers
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wsel_q   <= fpt_pkg::RST_WSEL;
			fd_lo_q  <= fpt_pkg::RST_FD_LO;
			fd_up_q  <= fpt_pkg::RST_FD_UP;
			pump_q   <= fpt_pkg::RST_PUMP;
			boost_q  <= fpt_pkg::RST_BOOST;
			dither_q <= fpt_pkg::RST_DITHER;
		end else if (latch) begin
			if (ctl == fpt_pkg::CTL_DEN_LO) begin
				wsel_q  <= sh_q[fpt_pkg::WSEL_BIT];
				fd_lo_q <= sh_q[fpt_pkg::DEN_LO_LSB +: 12];
			end
			if (ctl == fpt_pkg::CTL_DEN_UP) begin
				fd_up_q <= sh_q[fpt_pkg::DEN_UP_LSB +: 10];
			end
			if (ctl == fpt_pkg::CTL_TUNE) begin
				pump_q   <= sh_q[fpt_pkg::PUMP_LSB +: 3];
				boost_q  <= sh_q[fpt_pkg::BOOST_LSB +: 2];
				dither_q <= sh_q[fpt_pkg::DITHER_LSB +: 2];
			end
		end
	end

	// ****************************************************************
	// Decoded outputs
	// ****************************************************************
	wire pump_bad   = (pump_q != fpt_pkg::PUMP_MIN) && (pump_q != fpt_pkg::PUMP_MAX)
		&& (pump_q != fpt_pkg::PUMP_NOM);
	wire boost_bad  = (boost_q != fpt_pkg::BOOST_DOUBLE) && (boost_q != fpt_pkg::BOOST_OFF);
	wire dither_bad = (dither_q != fpt_pkg::DITHER_ON)
		&& (dither_q != fpt_pkg::DITHER_OFF);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			den          <= 22'h00_0000;
			den_wide     <= 1'b0;
			pump_mode    <= fpt_pkg::RST_PUMP;
			boost_double <= 1'b0;
			dither_en    <= 1'b0;
			code_err     <= 1'b0;
		end else begin
			den          <= wsel_q ? {fd_up_q, fd_lo_q} : {10'h000, fd_lo_q};
			den_wide     <= wsel_q;
			pump_mode    <= pump_q;
			boost_double <= (boost_q == fpt_pkg::BOOST_DOUBLE);
			dither_en    <= (dither_q == fpt_pkg::DITHER_ON);
			code_err     <= pump_bad || boost_bad || dither_bad;
		end
	end

endmodule : fpt_dev

`default_nettype wire

/* File: testbench/fpt_chk.sv */
// Purpose: Wire checks on the serial programming link.
// Assumes: The host changes the link only just after hclk edges.
// Notes:   Words are rebuilt from the wire so that their fields can be judged.
`timescale 1ns/100ps
`default_nettype none

module fpt_chk (
	input wire logic hclk,     // common clock
	input wire logic hresetn,  // async reset, active low
	input wire logic ser_clk,  // serial clock
	input wire logic ser_data, // serial data
	input wire logic ser_le    // load enable
);
	// ****************************************************************
	// Word rebuild
	// ****************************************************************
	logic        clk_q;
	logic        le_q;
	logic [23:0] sh_q;
	logic [5:0]  cnt_q;
	logic [9:0]  up_q;
	logic [11:0] lo_q;
	logic        wide_q;
	wire         rise  = ser_clk & ~clk_q;
	wire         latch = ser_le & ~le_q;
	wire         tune  = latch && sh_q[3:0] == fpt_pkg::CTL_TUNE;
	wire  [12:0] pad   = {sh_q[23:20], sh_q[17:12], sh_q[9:8], sh_q[4]};
	wire  [2:0]  pump  = sh_q[7:5];
	wire  [1:0]  boost = sh_q[11:10];
	wire  [1:0]  dsel  = sh_q[19:18];
	wire  [21:0] den_w = wide_q ? {up_q, lo_q} : {10'h000, lo_q};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_q <= 1'b0;
			le_q  <= 1'b0;
			sh_q  <= 24'h00_0000;
			cnt_q <= 6'h00;
		end else begin
			clk_q <= ser_clk;
			le_q  <= ser_le;
			sh_q  <= rise ? {sh_q[22:0], ser_data} : sh_q;
			cnt_q <= ser_le ? 6'h00 : cnt_q + {5'h00, rise};
		end
	end

	// The device's view of the denominator is kept so dithering can be judged.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_q   <= 10'h000;
			lo_q   <= 12'h000;
			wide_q <= 1'b0;
		end else if (latch && sh_q[3:0] == fpt_pkg::CTL_DEN_UP) begin
			up_q <= sh_q[23:14];
		end else if (latch && sh_q[3:0] == fpt_pkg::CTL_DEN_LO) begin
			lo_q   <= sh_q[15:4];
			wide_q <= sh_q[16];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence le_pulse_s;
		ser_le ##1 ser_le ##1 !ser_le;
	endsequence

	sequence clk_high_s;
		ser_clk ##1 ser_clk ##1 !ser_clk;
	endsequence

	le_count_a: assert property (latch |-> cnt_q == 6'h18)
		else $error("load strobe not after exactly 24 bits");
	le_pulse_a: assert property (latch |-> le_pulse_s)
		else $error("load strobe width wrong");
	clk_high_a: assert property ($rose(ser_clk) |-> clk_high_s)
		else $error("serial clock high time wrong");
	data_hold_a: assert property (ser_clk |-> $stable(ser_data))
		else $error("serial data moved while clock high");
	le_clk_a: assert property (ser_le |-> !ser_clk)
		else $error("serial clock high during load strobe");
	tune_zero_a: assert property (tune |-> pad == 13'h0000)
		else $error("tuning word has a nonzero fixed bit");
	pump_code_a: assert property (tune |-> pump inside {3'h2, 3'h3, 3'h7})
		else $error("reserved pump mode code sent");
	boost_code_a: assert property (tune |-> boost inside {2'h2, 2'h3})
		else $error("reserved boost code sent");
	dither_code_a: assert property (tune |-> dsel inside {2'h0, 2'h3})
		else $error("reserved dither code sent");
	dither_den_a: assert property (tune && dsel == 2'h0
		|-> den_w >= fpt_pkg::DITHER_MIN_DEN)
		else $error("dither enabled with a small denominator");

endmodule : fpt_chk

`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the host and device tuning link.
// Assumes: One AHB-Lite master with the host as its only slave.
// Notes:   Device fields are judged only after the link has gone idle.
`timescale 1ns/100ps
`default_nettype none

module tb;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire  [21:0] den;
	wire         den_wide;
	wire  [2:0]  pump_mode;
	wire         boost_double;
	wire         dither_en;
	wire         code_err;
	int          errors;
	int          compares;

	fpt_ser_if ser_if (.hclk(hclk), .hresetn(hresetn));
	fpt_host u_fpt_host (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ser(ser_if.host)
	);
	fpt_dev u_fpt_dev (
		.hclk(hclk), .hresetn(hresetn), .ser(ser_if.dev), .den(den), .den_wide(den_wide),
		.pump_mode(pump_mode), .boost_double(boost_double), .dither_en(dither_en),
		.code_err(code_err)
	);
	fpt_chk u_chk (
		.hclk(hclk), .hresetn(hresetn), .ser_clk(ser_if.ser_clk),
		.ser_data(ser_if.ser_data), .ser_le(ser_if.ser_le)
	);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic finish_test();
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Long waits are legal: a write stalls while earlier words still shift.
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 400);
		if (hreadyout !== 1'b1) begin
			chk("hready_wait", 32'h0000_0001, {31'h0, hreadyout});
			finish_test();
		end
	endtask : wait_rdy

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb(1'b0, a, 32'h0000_0000, q);
		chk(nm, exp, q);
	endtask : rdc

	// Polls the busy flag, then allows the device eight clocks for its update lag.
	task automatic settle();
		logic [31:0] s;
		int          n;
		n = 0;
		do begin
			ahb(1'b0, fpt_pkg::OFS_STAT, 32'h0000_0000, s);
			n++;
		end while (s[fpt_pkg::STAT_BUSY] !== 1'b0 && n < 200);
		if (s[fpt_pkg::STAT_BUSY] !== 1'b0) begin
			chk("busy", 32'h0000_0000, s);
			finish_test();
		end
		repeat (8) @(posedge hclk);
	endtask : settle

	task automatic chk_dev(input logic [21:0] d, input logic w, input logic [2:0] p,
		input logic b, input logic t);
		chk("den", {10'h0, d}, {10'h0, den});
		chk("den_wide", {31'h0, w}, {31'h0, den_wide});
		chk("pump_mode", {29'h0, p}, {29'h0, pump_mode});
		chk("boost_double", {31'h0, b}, {31'h0, boost_double});
		chk("dither_en", {31'h0, t}, {31'h0, dither_en});
		chk("code_err", 32'h0000_0000, {31'h0, code_err});
	endtask : chk_dev

	function automatic logic [31:0] tw(input logic [2:0] p, input logic [1:0] b,
		input logic [1:0] d);
		return {22'h0, d, 2'h0, b, 1'b0, p};
	endfunction : tw

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		rdc("ctrl", fpt_pkg::OFS_CTRL, 32'h0000_0000);
		rdc("tune", fpt_pkg::OFS_TUNE, tw(3'h7, 2'h3, 2'h3));
		wr(8'h10, 32'hffff_ffff);
		rdc("unmapped", 8'h10, 32'h0000_0000);
		rdc("stat", fpt_pkg::OFS_STAT, 32'h0000_0000);
		chk_dev(22'h00_0000, 1'b0, 3'h7, 1'b0, 1'b0);
	endtask : t_reset

	task automatic t_den12();
		wr(fpt_pkg::OFS_DEN, 32'h0000_1000);
		rdc("stat", fpt_pkg::OFS_STAT, 32'h0000_0002);
		wr(fpt_pkg::OFS_STAT, 32'h0000_0002);
		wr(fpt_pkg::OFS_DEN, 32'hffc0_0fff);
		settle();
		chk_dev(22'h00_0fff, 1'b0, 3'h7, 1'b0, 1'b0);
		rdc("den_rb", fpt_pkg::OFS_DEN, 32'h0000_0fff);
	endtask : t_den12

	task automatic t_den22();
		wr(fpt_pkg::OFS_CTRL, 32'h0000_0001);
		wr(fpt_pkg::OFS_DEN, 32'h003f_ffff);
		settle();
		chk_dev(22'h3f_ffff, 1'b1, 3'h7, 1'b0, 1'b0);
		wr(fpt_pkg::OFS_DEN, 32'h0000_1000);
		settle();
		chk_dev(22'h00_1000, 1'b1, 3'h7, 1'b0, 1'b0);
		wr(fpt_pkg::OFS_DEN, 32'h0000_0fff);
		settle();
		chk_dev(22'h00_0fff, 1'b1, 3'h7, 1'b0, 1'b0);
		wr(fpt_pkg::OFS_CTRL, 32'h0000_0000);
		wr(fpt_pkg::OFS_DEN, 32'h0000_0155);
		settle();
		chk_dev(22'h00_0155, 1'b0, 3'h7, 1'b0, 1'b0);
	endtask : t_den22

	task automatic t_tune();
		logic [2:0] pc [3];
		pc = '{3'h2, 3'h3, 3'h7};
		for (int i = 0; i < 3; i++) begin
			for (int j = 2; j < 4; j++) begin
				wr(fpt_pkg::OFS_TUNE, tw(pc[i], 2'(j), 2'h3));
				settle();
				chk_dev(22'h00_0155, 1'b0, pc[i], j == 2, 1'b0);
				rdc("tune_rb", fpt_pkg::OFS_TUNE, tw(pc[i], 2'(j), 2'h3));
			end
		end
	endtask : t_tune

	// Control, denominator and tuning go back to back; the last one stalls.
	task automatic t_dither(input logic [31:0] c, input logic [21:0] d, input logic en,
		input logic [31:0] st);
		wr(fpt_pkg::OFS_CTRL, c);
		wr(fpt_pkg::OFS_DEN, {10'h0, d});
		wr(fpt_pkg::OFS_TUNE, tw(3'h7, 2'h3, 2'h0));
		settle();
		chk_dev(d, 1'b0, 3'h7, 1'b0, en);
		rdc("stat", fpt_pkg::OFS_STAT, st);
		wr(fpt_pkg::OFS_STAT, 32'h0000_0004);
	endtask : t_dither

	task automatic t_refuse();
		logic [31:0] bad [9];
		bad = '{tw(3'h0, 2'h3, 2'h3), tw(3'h1, 2'h3, 2'h3), tw(3'h4, 2'h3, 2'h3),
			tw(3'h5, 2'h3, 2'h3), tw(3'h6, 2'h3, 2'h3), tw(3'h7, 2'h0, 2'h3),
			tw(3'h7, 2'h1, 2'h3), tw(3'h7, 2'h3, 2'h1), tw(3'h7, 2'h3, 2'h2)};
		for (int i = 0; i < 9; i++) begin
			wr(fpt_pkg::OFS_TUNE, bad[i]);
			rdc("stat", fpt_pkg::OFS_STAT, 32'h0000_0002);
			wr(fpt_pkg::OFS_STAT, 32'h0000_0002);
		end
		repeat (8) @(posedge hclk);
		chk_dev(22'h00_03e8, 1'b0, 3'h7, 1'b0, 1'b0);
	endtask : t_refuse

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		hresetn  = 1'b0;
		hsel     = 1'b0;
		haddr    = 32'h0000_0000;
		htrans   = 2'h0;
		hwrite   = 1'b0;
		hsize    = 3'h2;
		hwdata   = 32'h0000_0000;
		errors   = 0;
		compares = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_den12();
		t_den22();
		t_tune();
		t_dither(32'h0000_0000, 22'h00_03e8, 1'b1, 32'h0000_0000);
		t_dither(32'h0000_0000, 22'h00_03e7, 1'b0, 32'h0000_0004);
		t_dither(32'h0000_0000, 22'h00_03e8, 1'b1, 32'h0000_0000);
		t_dither(32'h0000_0002, 22'h00_03e8, 1'b0, 32'h0000_0004);
		t_refuse();
		finish_test();
	end

endmodule : tb

`default_nettype wire
